// ---- ppf_board.sv ----
// board-side pin model: device driver, outside driver, pull-up or drifting float
`timescale 1ns/1ns
module ppf_board
#(
  parameter int W = 1
)(
  input  wire logic         i_clk,
  input  wire logic [W-1:0] i_oe,
  input  wire logic [W-1:0] i_out,
  input  wire logic [W-1:0] i_pu,
  input  wire logic [W-1:0] i_ext_en,
  input  wire logic [W-1:0] i_ext_val,
  output logic      [W-1:0] o_pin
);
  // ------------------------------
  // wire level
  // ------------------------------
  logic [W-1:0] last = '0;
  // a released line without pull-up flips each cycle so a stale value never passes
  always_ff @(posedge i_clk)
    last <= o_pin;
  always_comb
    for (int k = 0; k < W; k++)
      o_pin[k] = i_oe[k] ? i_out[k] : i_ext_en[k] ? i_ext_val[k] : i_pu[k] | ~last[k];
endmodule

// ---- ppf_irq_capture.sv ----
// asynchronous interrupt pin capture
`timescale 1ns/1ns
module ppf_irq_capture
  import ppf_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_irq_pin_n,
  input  wire logic i_irq_ack,
  output logic      o_irq_level,
  output logic      o_irq_pend
);
  logic irq_q;
  logic prev;
  logic next_pend;
  logic next_prev;

  ppf_sync #(.W(1), .INIT(1'b1)) u_sync
  (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_async (i_irq_pin_n),
    .o_sync  (irq_q)
  );

  always_comb
  begin
    next_prev = irq_q;
    next_pend = o_irq_pend;
    if (i_irq_ack)
    begin
      next_pend = 1'b0;
    end
    // set wins over acknowledge in the same cycle
    if (prev && !irq_q)
    begin
      next_pend = 1'b1;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      prev       <= 1'b1;
      o_irq_pend <= 1'b0;
    end
    else
    begin
      prev       <= next_prev;
      o_irq_pend <= next_pend;
    end
  end

  assign o_irq_level = ~irq_q;
endmodule

// ---- ppf_map.svh ----
// constants for the port pin function and pull-up control block
`ifndef PPF_MAP_SVH
`define PPF_MAP_SVH
`define PPF_PA_W        4
`define PPF_PB_W        6
`define PPF_PC_W        2
`define PPF_PD_W        7
`define PPF_PE_W        2
`define PPF_PD_SPI_W    4
`define PPF_PD_TIM_W    3
`define PPF_PE_TX_BIT   0
`define PPF_PE_RX_BIT   1
`define PPF_RST_STRETCH 8'h20
`endif

// ---- ppf_pkg.sv ----
// types for the port pin function and pull-up control block
package ppf_pkg;
  typedef enum logic [1:0] {
    PPF_RST_RUN   = 2'b00,
    PPF_RST_DRIVE = 2'b01,
    PPF_RST_WAIT  = 2'b10
  } ppf_rst_state_type;
endpackage

// ---- ppf_sync.sv ----
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ns
module ppf_sync
  import ppf_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
)(
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_out;

  // a bit only changes once the second and third stages agree
  always_comb
  begin
    for (int k = 0; k < W; k++)
    begin
      next_out[k] = (s2[k] == s3[k]) ? s3[k] : o_sync[k];
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      s1     <= INIT;
      s2     <= INIT;
      s3     <= INIT;
      o_sync <= INIT;
    end
    else
    begin
      s1     <= i_async;
      s2     <= s1;
      s3     <= s2;
      o_sync <= next_out;
    end
  end
endmodule

// ---- ppf_top.sv ----
// pin function select, pull-up control, reset pin and illegal-address reset
`timescale 1ns/1ns
`include "ppf_map.svh"
module ppf_top
  import ppf_pkg::*;
(
  input  wire logic                       i_mclk,
  input  wire logic                       i_rst_n,
  // reset pin, open drain
  input  wire logic                       i_reset_pin,
  output logic                            o_reset_pin,
  output logic                            o_reset_pin_oe,
  input  wire logic                       i_int_reset_src,
  output logic                            o_sys_rst_n,
  // interrupt pin
  input  wire logic                       i_irq_pin_n,
  input  wire logic                       i_irq_ack,
  output logic                            o_irq_level,
  output logic                            o_irq_pend,
  // illegal address detection
  input  wire logic                       i_bus_access,
  input  wire logic                       i_addr_unimpl,
  input  wire logic                       i_illegal_addr_rst_en,
  output logic                            o_illegal_addr_rst,
  // port A
  input  wire logic [`PPF_PA_W-1:0]       i_port_a_pins,
  output logic      [`PPF_PA_W-1:0]       o_port_a_pins,
  output logic      [`PPF_PA_W-1:0]       o_port_a_pins_oe,
  output logic      [`PPF_PA_W-1:0]       o_port_a_pullup,
  input  wire logic [`PPF_PA_W-1:0]       i_port_a_data,
  input  wire logic [`PPF_PA_W-1:0]       i_port_a_dir,
  input  wire logic [`PPF_PA_W-1:0]       i_port_a_pullup_sel,
  input  wire logic [`PPF_PA_W-1:0]       i_keypad_wake_function,
  output logic      [`PPF_PA_W-1:0]       o_keypad_wake_inputs,
  output logic      [`PPF_PA_W-1:0]       o_port_a_in,
  // port B
  input  wire logic [`PPF_PB_W-1:0]       i_port_b_pins,
  output logic      [`PPF_PB_W-1:0]       o_port_b_pins,
  output logic      [`PPF_PB_W-1:0]       o_port_b_pins_oe,
  input  wire logic [`PPF_PB_W-1:0]       i_port_b_data,
  input  wire logic [`PPF_PB_W-1:0]       i_port_b_dir,
  input  wire logic [`PPF_PB_W-1:0]       i_analog_sel,
  output logic      [`PPF_PB_W-1:0]       o_analog_input_en,
  output logic      [`PPF_PB_W-1:0]       o_port_b_in,
  // port C
  input  wire logic [`PPF_PC_W-1:0]       i_port_c_pins,
  output logic      [`PPF_PC_W-1:0]       o_port_c_pins,
  output logic      [`PPF_PC_W-1:0]       o_port_c_pins_oe,
  output logic      [`PPF_PC_W-1:0]       o_port_c_pullup,
  input  wire logic [`PPF_PC_W-1:0]       i_port_c_data,
  input  wire logic [`PPF_PC_W-1:0]       i_port_c_dir,
  input  wire logic [`PPF_PC_W-1:0]       i_port_c_pullup_sel,
  output logic      [`PPF_PC_W-1:0]       o_port_c_in,
  // port D
  input  wire logic [`PPF_PD_W-1:0]       i_port_d_pins,
  output logic      [`PPF_PD_W-1:0]       o_port_d_pins,
  output logic      [`PPF_PD_W-1:0]       o_port_d_pins_oe,
  output logic      [`PPF_PD_W-1:0]       o_port_d_pullup,
  input  wire logic [`PPF_PD_W-1:0]       i_port_d_data,
  input  wire logic [`PPF_PD_W-1:0]       i_port_d_dir,
  input  wire logic [`PPF_PD_W-1:0]       i_port_d_pullup_sel,
  input  wire logic                       i_spi_enable,
  input  wire logic [`PPF_PD_SPI_W-1:0]   i_spi_out,
  input  wire logic [`PPF_PD_SPI_W-1:0]   i_spi_oe,
  output logic      [`PPF_PD_SPI_W-1:0]   o_spi_in,
  input  wire logic [`PPF_PD_TIM_W-1:0]   i_timer_ch_enable,
  input  wire logic [`PPF_PD_TIM_W-1:0]   i_timer_ch_out,
  input  wire logic [`PPF_PD_TIM_W-1:0]   i_timer_ch_oe,
  output logic      [`PPF_PD_TIM_W-1:0]   o_timer_ch_in,
  output logic      [`PPF_PD_W-1:0]       o_port_d_in,
  // port E
  input  wire logic [`PPF_PE_W-1:0]       i_port_e_pins,
  output logic      [`PPF_PE_W-1:0]       o_port_e_pins,
  output logic      [`PPF_PE_W-1:0]       o_port_e_pins_oe,
  input  wire logic [`PPF_PE_W-1:0]       i_port_e_data,
  input  wire logic [`PPF_PE_W-1:0]       i_port_e_dir,
  input  wire logic                       i_async_serial_enable,
  input  wire logic                       i_async_serial_tx,
  output logic                            o_async_serial_rx,
  output logic      [`PPF_PE_W-1:0]       o_port_e_in
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic                     rst_pin_q;
  logic [`PPF_PA_W-1:0]     pa_q;
  logic [`PPF_PB_W-1:0]     pb_q;
  logic [`PPF_PC_W-1:0]     pc_q;
  logic [`PPF_PD_W-1:0]     pd_q;
  logic [`PPF_PE_W-1:0]     pe_q;

  ppf_sync #(.W(1), .INIT(1'b0)) u_rst_sync
  (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_async (i_reset_pin),
    .o_sync  (rst_pin_q)
  );

  ppf_sync #(.W(`PPF_PA_W + `PPF_PB_W + `PPF_PC_W + `PPF_PD_W + `PPF_PE_W)) u_port_sync
  (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_async ({i_port_e_pins, i_port_d_pins, i_port_c_pins, i_port_b_pins, i_port_a_pins}),
    .o_sync  ({pe_q, pd_q, pc_q, pb_q, pa_q})
  );

  ppf_irq_capture u_irq
  (
    .i_mclk      (i_mclk),
    .i_rst_n     (i_rst_n),
    .i_irq_pin_n (i_irq_pin_n),
    .i_irq_ack   (i_irq_ack),
    .o_irq_level (o_irq_level),
    .o_irq_pend  (o_irq_pend)
  );

  // ----------------------------------------
  // reset pin and illegal-address reset
  // ----------------------------------------
  ppf_rst_state_type rst_state;
  ppf_rst_state_type next_rst_state;
  logic [7:0]        stretch;
  logic [7:0]        next_stretch;
  logic              illegal_q;
  logic              next_illegal;
  logic              any_internal;

  assign next_illegal = i_bus_access & i_addr_unimpl & i_illegal_addr_rst_en;
  assign any_internal = i_int_reset_src | illegal_q;

  always_comb
  begin
    next_rst_state = rst_state;
    next_stretch   = stretch;
    case (rst_state)
      PPF_RST_RUN:
      begin
        if (any_internal)
        begin
          next_rst_state = PPF_RST_DRIVE;
          next_stretch   = `PPF_RST_STRETCH;
        end
      end
      PPF_RST_DRIVE:
      begin
        // hold the pin low long enough for the board to see it
        if (any_internal)
        begin
          next_stretch = `PPF_RST_STRETCH;
        end
        else if (stretch != 8'h00)
        begin
          next_stretch = stretch - 8'h01;
        end
        else
        begin
          next_rst_state = PPF_RST_WAIT;
        end
      end
      PPF_RST_WAIT:
      begin
        // a new source restarts drive
        // a source that starts while waiting for the pin must not be lost
        if (any_internal)
        begin
          next_rst_state = PPF_RST_DRIVE;
          next_stretch   = `PPF_RST_STRETCH;
        end
        // released pin needs the synchroniser to see it high again
        else if (rst_pin_q)
        begin
          next_rst_state = PPF_RST_RUN;
        end
      end
      default:
      begin
        next_rst_state = PPF_RST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      rst_state <= PPF_RST_DRIVE;
      stretch   <= `PPF_RST_STRETCH;
      illegal_q <= 1'b0;
    end
    else
    begin
      rst_state <= next_rst_state;
      stretch   <= next_stretch;
      illegal_q <= next_illegal;
    end
  end

  assign o_reset_pin        = 1'b0;
  assign o_reset_pin_oe     = (rst_state == PPF_RST_DRIVE);
  assign o_illegal_addr_rst = illegal_q;
  assign o_sys_rst_n        = rst_pin_q & (rst_state == PPF_RST_RUN);

  // ----------------------------------------
  // shared decoding
  // ----------------------------------------
  // pull-up only where the pin is not driven, so the driver never fights it
  function automatic logic [`PPF_PD_W-1:0] ppf_in_pullup
  (
    input logic [`PPF_PD_W-1:0] sel,
    input logic [`PPF_PD_W-1:0] drv
  );
    return sel & ~drv;
  endfunction

  // per-bit choice between the owning peripheral and the port registers
  function automatic logic [`PPF_PD_W-1:0] ppf_owner_pick
  (
    input logic [`PPF_PD_W-1:0] own,
    input logic [`PPF_PD_W-1:0] per,
    input logic [`PPF_PD_W-1:0] prt
  );
    return (own & per) | (~own & prt);
  endfunction

  // narrow ports widened to the shared width; upper bits are unused
  logic [`PPF_PD_W-1:0] pa_pu_wide;
  logic [`PPF_PD_W-1:0] pc_pu_wide;

  // ----------------------------------------
  // port A: keypad wake
  // ----------------------------------------
  // per-bit keypad select
  assign o_keypad_wake_inputs = pa_q & i_keypad_wake_function;
  assign o_port_a_in          = pa_q;
  assign o_port_a_pins        = i_port_a_data;
  // a keypad pin is forced to input
  assign o_port_a_pins_oe     = i_port_a_dir & ~i_keypad_wake_function;
  assign pa_pu_wide      = ppf_in_pullup({3'h0, i_port_a_pullup_sel}, {3'h0, i_port_a_dir});
  assign o_port_a_pullup = i_keypad_wake_function | pa_pu_wide[`PPF_PA_W-1:0];

  // ----------------------------------------
  // port B: general I/O or analog
  // ----------------------------------------
  // analog disables digital driver
  assign o_analog_input_en = i_analog_sel;
  assign o_port_b_pins     = i_port_b_data;
  assign o_port_b_pins_oe  = i_port_b_dir & ~i_analog_sel;
  assign o_port_b_in       = pb_q & ~i_analog_sel;

  // ----------------------------------------
  // port C: plain I/O
  // ----------------------------------------
  // no alternate function
  assign o_port_c_pins    = i_port_c_data;
  assign o_port_c_pins_oe = i_port_c_dir;
  assign o_port_c_in      = pc_q;
  assign pc_pu_wide       = ppf_in_pullup({5'h00, i_port_c_pullup_sel}, {5'h00, i_port_c_dir});
  assign o_port_c_pullup  = pc_pu_wide[`PPF_PC_W-1:0];

  // ----------------------------------------
  // port D: serial peripheral and timers
  // ----------------------------------------
  logic [`PPF_PD_W-1:0] pd_own;
  logic [`PPF_PD_W-1:0] pd_pout;
  logic [`PPF_PD_W-1:0] pd_poe;

  // low four spi, upper three timers
  assign pd_own  = {i_timer_ch_enable, {`PPF_PD_SPI_W{i_spi_enable}}};
  assign pd_pout = {i_timer_ch_out, i_spi_out};
  assign pd_poe  = {i_timer_ch_oe, i_spi_oe};

  assign o_port_d_pins    = ppf_owner_pick(pd_own, pd_pout, i_port_d_data);
  assign o_port_d_pins_oe = ppf_owner_pick(pd_own, pd_poe, i_port_d_dir);
  assign o_port_d_pullup  = ppf_in_pullup(i_port_d_pullup_sel, o_port_d_pins_oe);
  assign o_spi_in         = pd_q[`PPF_PD_SPI_W-1:0];
  assign o_timer_ch_in    = pd_q[`PPF_PD_W-1:`PPF_PD_SPI_W];
  assign o_port_d_in      = pd_q;

  // ----------------------------------------
  // port E: async serial
  // ----------------------------------------
  // transmit and receive lines
  always_comb
  begin
    o_port_e_pins    = i_port_e_data;
    o_port_e_pins_oe = i_port_e_dir;
    if (i_async_serial_enable)
    begin
      o_port_e_pins[`PPF_PE_TX_BIT]    = i_async_serial_tx;
      o_port_e_pins_oe[`PPF_PE_TX_BIT] = 1'b1;
      o_port_e_pins[`PPF_PE_RX_BIT]    = 1'b0;
      o_port_e_pins_oe[`PPF_PE_RX_BIT] = 1'b0;
    end
  end

  // idle line reads high while the function is off
  assign o_async_serial_rx = i_async_serial_enable ? pe_q[`PPF_PE_RX_BIT] : 1'b1;
  assign o_port_e_in       = pe_q;
endmodule

// ---- ppf_top_checker.sv ----
// concurrent checks on the ports of the pin function block
`timescale 1ns/1ns
module ppf_top_checker
(
  input wire logic       i_mclk,
  input wire logic       i_rst_n,
  input wire logic       o_reset_pin_oe,
  input wire logic       i_int_reset_src,
  input wire logic       o_sys_rst_n,
  input wire logic       o_irq_level,
  input wire logic       o_irq_pend,
  input wire logic       i_bus_access,
  input wire logic       i_addr_unimpl,
  input wire logic       i_illegal_addr_rst_en,
  input wire logic       o_illegal_addr_rst,
  input wire logic [3:0] i_port_a_dir,
  input wire logic [3:0] i_port_a_pullup_sel,
  input wire logic [3:0] i_keypad_wake_function,
  input wire logic [3:0] o_port_a_pins_oe,
  input wire logic [3:0] o_port_a_pullup,
  input wire logic [1:0] i_port_c_dir,
  input wire logic [1:0] i_port_c_pullup_sel,
  input wire logic [1:0] o_port_c_pullup,
  input wire logic [6:0] i_port_d_pullup_sel,
  input wire logic [6:0] o_port_d_pins_oe,
  input wire logic [6:0] o_port_d_pullup
);
  // ------------------------------
  // properties
  // ------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  AST_PA_PULLUP:
    assert property (o_port_a_pullup ==
      (i_keypad_wake_function | (i_port_a_pullup_sel & ~i_port_a_dir))) else $error("pa pullup");
  AST_PA_OE:
    assert property (o_port_a_pins_oe == (i_port_a_dir & ~i_keypad_wake_function))
      else $error("pa oe");
  AST_PC_PULLUP:
    assert property (o_port_c_pullup == (i_port_c_pullup_sel & ~i_port_c_dir))
      else $error("pc pullup");
  AST_PD_PULLUP:
    assert property (o_port_d_pullup == (i_port_d_pullup_sel & ~o_port_d_pins_oe))
      else $error("pd pullup");
  AST_ILL_RST:
    assert property (1 |=> o_illegal_addr_rst ==
      $past(i_bus_access && i_addr_unimpl && i_illegal_addr_rst_en)) else $error("illegal");
  AST_RST_OUT:
    assert property (o_illegal_addr_rst && o_sys_rst_n |=> o_reset_pin_oe && !o_sys_rst_n)
      else $error("reset pin");
  AST_INT_SRC:
    assert property (i_int_reset_src ##1 i_int_reset_src |-> o_reset_pin_oe [*8])
      else $error("int source");
  AST_IRQ_PEND:
    assert property ($rose(o_irq_level) |-> ##[0:1] o_irq_pend) else $error("irq pend");
endmodule
bind ppf_top ppf_top_checker u_chk (.*);

// ---- ppf_top_tb_top.sv ----
// self-checking bench for the pin function block
`timescale 1ns/1ns
module ppf_top_tb_top;
  logic i_mclk = 1'b0, i_rst_n = 1'b0, i_int_reset_src = 1'b0, i_irq_ack = 1'b0;
  logic i_bus_access = 1'b0, i_addr_unimpl = 1'b0, i_illegal_addr_rst_en = 1'b0;
  logic i_spi_enable = 1'b0, i_async_serial_enable = 1'b0, i_async_serial_tx = 1'b0;
  logic i_reset_pin, o_reset_pin, o_reset_pin_oe, o_sys_rst_n, i_irq_pin_n, o_irq_level;
  logic o_irq_pend, o_illegal_addr_rst, o_async_serial_rx, rst_ext = 1'b0, irq_ext = 1'b0;
  logic [3:0] i_port_a_pins, o_port_a_pins, o_port_a_pins_oe, o_port_a_pullup, o_port_a_in;
  logic [3:0] i_port_a_data = 4'h0, i_port_a_dir = 4'h0, i_port_a_pullup_sel = 4'h0;
  logic [3:0] i_keypad_wake_function = 4'h0, o_keypad_wake_inputs, o_spi_in;
  logic [3:0] i_spi_out = 4'h0, i_spi_oe = 4'h0;
  logic [5:0] i_port_b_pins, o_port_b_pins, o_port_b_pins_oe, o_analog_input_en, o_port_b_in;
  logic [5:0] i_port_b_data = 6'h00, i_port_b_dir = 6'h00, i_analog_sel = 6'h00;
  logic [1:0] i_port_c_pins, o_port_c_pins, o_port_c_pins_oe, o_port_c_pullup, o_port_c_in;
  logic [1:0] i_port_c_data = 2'h0, i_port_c_dir = 2'h0, i_port_c_pullup_sel = 2'h0;
  logic [6:0] i_port_d_pins, o_port_d_pins, o_port_d_pins_oe, o_port_d_pullup, o_port_d_in;
  logic [6:0] i_port_d_data = 7'h00, i_port_d_dir = 7'h00, i_port_d_pullup_sel = 7'h00;
  logic [2:0] i_timer_ch_enable = 3'h0, i_timer_ch_out = 3'h0, i_timer_ch_oe = 3'h0;
  logic [2:0] o_timer_ch_in;
  logic [1:0] i_port_e_pins, o_port_e_pins, o_port_e_pins_oe, o_port_e_in;
  logic [1:0] i_port_e_data = 2'h0, i_port_e_dir = 2'h0;
  logic [6:0] ext_en = 7'h00, ext_val = 7'h00;
  logic [7:0] ex;
  int         checks = 0, miscompares = 0, cyc = 0;

  ppf_top dut (.*);
  logic [1:0] ctl_pin;
  // reset pin on bit 0, interrupt pin on bit 1; both carry a board pull-up
  ppf_board #(.W(2)) u_ctl (.i_clk(i_mclk), .i_oe({1'b0, o_reset_pin_oe}),
    .i_out({2{o_reset_pin}}), .i_pu(2'h3), .i_ext_en({irq_ext, rst_ext}), .i_ext_val(2'h0),
    .o_pin(ctl_pin));
  assign {i_irq_pin_n, i_reset_pin} = ctl_pin;
  ppf_board #(.W(4)) u_pa (.i_clk(i_mclk), .i_oe(o_port_a_pins_oe), .i_out(o_port_a_pins),
    .i_pu(o_port_a_pullup), .i_ext_en(ext_en[3:0]), .i_ext_val(ext_val[3:0]),
    .o_pin(i_port_a_pins));
  ppf_board #(.W(6)) u_pb (.i_clk(i_mclk), .i_oe(o_port_b_pins_oe), .i_out(o_port_b_pins),
    .i_pu(6'h00), .i_ext_en(ext_en[5:0]), .i_ext_val(ext_val[5:0]), .o_pin(i_port_b_pins));
  ppf_board #(.W(2)) u_pc (.i_clk(i_mclk), .i_oe(o_port_c_pins_oe), .i_out(o_port_c_pins),
    .i_pu(o_port_c_pullup), .i_ext_en(ext_en[1:0]), .i_ext_val(ext_val[1:0]),
    .o_pin(i_port_c_pins));
  ppf_board #(.W(7)) u_pd (.i_clk(i_mclk), .i_oe(o_port_d_pins_oe), .i_out(o_port_d_pins),
    .i_pu(o_port_d_pullup), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin(i_port_d_pins));
  ppf_board #(.W(2)) u_pe (.i_clk(i_mclk), .i_oe(o_port_e_pins_oe), .i_out(o_port_e_pins),
    .i_pu(2'h0), .i_ext_en(ext_en[1:0]), .i_ext_val(ext_val[1:0]), .o_pin(i_port_e_pins));

  // ------------------------------
  // clock, timeout and tasks
  // ------------------------------
  always #2 i_mclk = ~i_mclk;
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  // bounded wait for the device to leave reset
  task automatic wait_run();
    for (int n = 0; n < 120 && o_sys_rst_n !== 1'b1; n++)
      tick(1);
  endtask
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ------------------------------
  // tests
  // ------------------------------
  initial
  begin
    tick(2);
    cmp({5'h00, o_reset_pin, o_reset_pin_oe, o_sys_rst_n}, 8'h02);
    @(posedge i_mclk);
    i_rst_n <= 1'b1;
    wait_run();
    cmp({7'h00, o_sys_rst_n}, 8'h01);
    for (int i = 0; i < 256; i++)
    begin
      @(posedge i_mclk);
      {i_port_a_dir, i_port_a_pullup_sel, i_keypad_wake_function} <= {i[7:0], i[5:2]};
      {i_port_a_data, i_port_b_data, i_port_c_data} <= {i[3:0], ~i[7:2], ~i[1:0]};
      {i_port_b_dir, i_analog_sel, i_port_c_dir, i_port_c_pullup_sel} <= {i[5:0], i[7:2], i[3:0]};
      {i_port_d_dir, i_port_d_data, i_port_d_pullup_sel} <= {i[6:0], i[7:1], ~i[6:0]};
      {i_spi_enable, i_spi_out, i_spi_oe, i_timer_ch_enable} <= {i[7:3], i[4:1], i[2:0]};
      {i_timer_ch_out, i_timer_ch_oe, i_port_e_dir, i_port_e_data} <=
        {~i[7:5], i[5:3], i[2:1], i[4:3]};
      {i_async_serial_enable, i_async_serial_tx} <= {i[0], i[6]};
      tick(1);
      cmp(8'(o_port_a_pullup), 8'(i[5:2] | (i[3:0] & ~i[7:4])));
      cmp(8'(o_port_a_pins_oe), 8'(i[7:4] & ~i[5:2]));
      cmp(8'(o_port_b_pins_oe), 8'(i[5:0] & ~i[7:2]));
      cmp(8'(o_analog_input_en), {2'h0, i[7:2]});
      cmp(8'(o_port_b_pins), {2'h0, ~i[7:2]});
      cmp({o_port_a_pins, o_port_c_pins, o_port_c_pins_oe}, {i[3:0], ~i[1:0], i[3:2]});
      cmp(8'(o_port_c_pullup), 8'(i[1:0] & ~i[3:2]));
      ex = {1'b0, (i[2:0] & i[5:3]) | (~i[2:0] & i[6:4]), i[7] ? i[4:1] : i[3:0]};
      cmp(8'(o_port_d_pins_oe), ex);
      cmp({1'b0, ~i[6:0] & ~ex[6:0]}, 8'(o_port_d_pullup));
      ex = {1'b0, (i[2:0] & ~i[7:5]) | (~i[2:0] & i[7:5]), i[7] ? i[6:3] : i[4:1]};
      cmp(8'(o_port_d_pins), ex);
      ex = i[0] ? {4'h0, 1'b0, 1'b1, 1'b0, i[6]} : {4'h0, i[2:1], i[4:3]};
      cmp({4'h0, o_port_e_pins_oe, o_port_e_pins[1] & o_port_e_pins_oe[1], o_port_e_pins[0]},
        {4'h0, ex[3:2], ex[1] & ex[3], ex[0]});
    end
    @(posedge i_mclk);
    {i_port_a_dir, i_keypad_wake_function, i_async_serial_enable} <= {4'h0, 4'h5, 1'b1};
    {ext_en, ext_val} <= {7'h0F, 7'h04};
    {i_port_b_dir, i_analog_sel, i_port_c_dir} <= {6'h00, 6'h30, 2'h0};
    {i_port_d_dir, i_port_d_pullup_sel, i_spi_enable, i_timer_ch_enable} <=
      {7'h00, 7'h70, 1'b0, 3'h0};
    tick(6);
    cmp({o_keypad_wake_inputs, o_port_a_in}, 8'h44);
    cmp({o_port_b_in, o_port_c_in}, 8'h10);
    cmp({1'b0, o_port_d_in}, 8'h74);
    cmp({o_timer_ch_in, o_spi_in, o_port_e_in[0]}, 8'hE9);
    cmp({7'h00, o_async_serial_rx}, 8'h00);
    // only unimplemented places are touched, never reserved ones
    for (int en = 0; en < 2; en++)
    begin
      @(posedge i_mclk);
      {i_bus_access, i_addr_unimpl, i_illegal_addr_rst_en} <= {2'b11, en[0]};
      @(posedge i_mclk);
      {i_bus_access, i_addr_unimpl} <= 2'b00;
      tick(0);
      cmp({7'h00, o_illegal_addr_rst}, 8'(en));
      tick(1);
      cmp({6'h00, o_reset_pin_oe, o_sys_rst_n}, en ? 8'h02 : 8'h01);
      wait_run();
    end
    @(posedge i_mclk);
    i_int_reset_src <= 1'b1;
    tick(4);
    @(posedge i_mclk);
    i_int_reset_src <= 1'b0;
    tick(30);
    cmp({6'h00, o_reset_pin_oe, o_sys_rst_n}, 8'h02);
    wait_run();
    @(posedge i_mclk);
    rst_ext <= 1'b1;
    tick(10);
    cmp({7'h00, o_sys_rst_n}, 8'h00);
    @(posedge i_mclk);
    rst_ext <= 1'b0;
    wait_run();
    @(posedge i_mclk);
    irq_ext <= 1'b1;
    tick(7);
    cmp({6'h00, o_irq_level, o_irq_pend}, 8'h03);
    @(posedge i_mclk);
    {irq_ext, i_irq_ack} <= 2'b01;
    @(posedge i_mclk);
    i_irq_ack <= 1'b0;
    tick(2);
    cmp({7'h00, o_irq_pend}, 8'h00);
    end_of_test();
  end
endmodule
